// [core/cbt_consts.svh]
/*
  Constants for the bit timing and address map block: byte offsets,
  field positions, reset values and timing figures.
  Assumes a 14-bit APB byte address and 32-bit data.
*/
`ifndef CBT_CONSTS_SVH
`define CBT_CONSTS_SVH

// ==========================================================
// Region bases and sizes (byte addresses)
`define CBT_CTRL_BASE 14'h0000
`define CBT_MBX_BASE 14'h2000
`define CBT_CRAM_OFS 14'h1000
`define CBT_COMPAT_CTRL_SIZE 14'h0100
`define CBT_FULL_CTRL_LAST 14'h007C
`define CBT_MBX_STRIDE 14'h0010
`define CBT_COMPAT_MBX_COUNT 16
`define CBT_FULL_MBX_COUNT 32
`define CBT_CRAM_WORDS_PER_MBX 3

// ==========================================================
// Control register offsets
`define CBT_BIT_TIMING_CONFIG 14'h0000
`define CBT_MODE_CONTROL 14'h0004
`define CBT_TX_PIN_IO_CONTROL 14'h0008
`define CBT_RX_PIN_IO_CONTROL 14'h000C
`define CBT_TIMING_STATUS 14'h0010
`define CBT_COMPAT_MASK0 14'h0020
`define CBT_COMPAT_MASK1 14'h0024
`define CBT_COMPAT_MASK2 14'h0028

// ==========================================================
// Bit timing config fields (counts hold value minus one; bit 7 is the triple sample flag)
`define CBT_SECOND_SEG_LSB 0
`define CBT_FIRST_SEG_LSB 3
`define CBT_TRIPLE_BIT 7
`define CBT_JUMP_LSB 8
`define CBT_PRESCALE_LSB 16

// Pin io control fields
`define CBT_IO_IN_BIT 0
`define CBT_IO_OUT_BIT 1
`define CBT_IO_DIR_BIT 2
`define CBT_IO_FUNC_BIT 3

// Mode control: set selects the full map
`define CBT_FULL_MODE_BIT 0

// ==========================================================
// Reset values
`define CBT_BTC_RESET 32'h0000_0000
`define CBT_MODE_RESET 1'b0
`define CBT_IO_RESET 4'h0
`define CBT_MASK_RESET 32'h0000_0000

// ==========================================================
// Timing figures
`define CBT_SYNC_TQ 1
`define CBT_PROC_QUANTA 3
`define CBT_SECOND_SEG_MIN 2
`define CBT_PCLK_HZ 25000000

`endif

// [core/cbt_pkg.sv]
/*
  Types shared by the bit timing and address map block.
  Assumes cbt_consts.svh carries every number.
*/
package cbt_pkg;

  // ========================================================
  // Bit segment state, Gray coded along sync, seg1, seg2
  typedef enum logic [1:0] {
    CBT_SYNC = 2'b00,
    CBT_SEG1 = 2'b01,
    CBT_SEG2 = 2'b11
  } cbt_seg_t;

  // ========================================================
  // Address region hit by an APB access
  typedef enum logic [1:0] {
    CBT_REG_NONE = 2'b00,
    CBT_REG_CTRL = 2'b01,
    CBT_REG_MBX = 2'b10,
    CBT_REG_CRAM = 2'b11
  } cbt_region_t;

endpackage

// [core/cbt_bit_timer.sv]
/*
  Time quantum prescaler and nominal bit segmenter with resync
  and optional triple sampling.
  Assumes rx_level is already synchronised to clk.
*/
`include "cbt_consts.svh"

module cbt_bit_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Configuration, fields as programmed
  input wire logic enable,
  input wire logic [7:0] quantum_prescaler,
  input wire logic [3:0] first_timing_segment,
  input wire logic [2:0] second_timing_segment,
  input wire logic [1:0] resync_jump_width,
  input wire logic triple_sample_select,
  // Bus level
  input wire logic rx_level,
  // Bit events
  output logic sample_strobe,
  output logic sampled_bit,
  output logic bit_start,
  output cbt_pkg::cbt_seg_t seg
);

  logic [7:0] tq_cnt; // Clocks within a quantum
  logic tq_tick; // Last clock of a quantum
  logic [4:0] qcnt; // Quantum within segment
  logic [4:0] seg1_len; // Seg1 length, grows on resync
  logic [4:0] seg2_len; // Seg2 length, shrinks on resync
  logic [4:0] t2_calc; // Programmed seg2 length
  logic [4:0] jump_quanta; // Jump width in quanta
  logic resync_done; // One resync per bit
  logic prev_rx; // Last level for edge detect
  logic edge_pend; // Falling edge seen this quantum
  logic [2:0] hist; // Last three quantum samples

  assign t2_calc = ({2'b00, second_timing_segment} + 5'd1 <
    5'(`CBT_SECOND_SEG_MIN)) ? 5'(`CBT_SECOND_SEG_MIN) :
    {2'b00, second_timing_segment} + 5'd1;
  assign jump_quanta = {3'b000, resync_jump_width} + 5'd1;
  assign tq_tick = enable && (tq_cnt == quantum_prescaler);

  // ========================================================
  // Quantum prescaler
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tq_cnt <= 8'h00;
    end else if (!enable || tq_tick) begin
      tq_cnt <= 8'h00;
    end else begin
      tq_cnt <= tq_cnt + 8'h01;
    end
  end

  // ========================================================
  // Edge capture; only recessive to dominant resyncs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_rx <= 1'b1;
      edge_pend <= 1'b0;
    end else begin
      prev_rx <= rx_level;
      if (prev_rx && !rx_level) begin
        edge_pend <= 1'b1;
      end else if (tq_tick) begin
        edge_pend <= 1'b0;
      end
    end
  end

  // ========================================================
  // Quantum sample history for triple sampling
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hist <= 3'h7;
    end else if (tq_tick) begin
      hist <= {hist[1:0], rx_level};
    end
  end

  // ========================================================
  // Segment sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seg <= cbt_pkg::CBT_SYNC;
      qcnt <= 5'h00;
      seg1_len <= 5'h01;
      seg2_len <= 5'h02;
      resync_done <= 1'b0;
      sample_strobe <= 1'b0;
      sampled_bit <= 1'b1;
      bit_start <= 1'b0;
    end else begin
      sample_strobe <= 1'b0;
      bit_start <= 1'b0;
      if (!enable) begin
        seg <= cbt_pkg::CBT_SYNC;
      end else if (tq_tick) begin
        unique case (seg)
          cbt_pkg::CBT_SYNC: begin
            seg <= cbt_pkg::CBT_SEG1;
            qcnt <= 5'h01;
            seg1_len <= {1'b0, first_timing_segment} + 5'd1;
            seg2_len <= t2_calc;
            resync_done <= 1'b0;
            bit_start <= 1'b1;
          end
          cbt_pkg::CBT_SEG1: begin
            if (edge_pend && !resync_done && qcnt < seg1_len) begin
              seg1_len <= seg1_len + jump_quanta;
              resync_done <= 1'b1;
              qcnt <= qcnt + 5'h01;
            end else if (qcnt >= seg1_len) begin
              seg <= cbt_pkg::CBT_SEG2;
              qcnt <= 5'h01;
              sample_strobe <= 1'b1;
              // Majority vote only when selected
              sampled_bit <= triple_sample_select ?
                ((hist[0] & hist[1]) | (hist[0] & hist[2]) |
                 (hist[1] & hist[2])) : rx_level;
            end else begin
              qcnt <= qcnt + 5'h01;
            end
          end
          cbt_pkg::CBT_SEG2: begin
            if (edge_pend && !resync_done &&
                (seg2_len - qcnt) <= jump_quanta) begin
              // Edge stands in for the next sync quantum
              seg <= cbt_pkg::CBT_SEG1;
              qcnt <= 5'h01;
              seg1_len <= {1'b0, first_timing_segment} + 5'd1;
              seg2_len <= t2_calc;
              bit_start <= 1'b1;
            end else if (edge_pend && !resync_done) begin
              seg2_len <= seg2_len - jump_quanta;
              resync_done <= 1'b1;
              qcnt <= qcnt + 5'h01;
            end else if (qcnt >= seg2_len) begin
              seg <= cbt_pkg::CBT_SYNC;
            end else begin
              qcnt <= qcnt + 5'h01;
            end
          end
          default: begin
            seg <= cbt_pkg::CBT_SYNC;
          end
        endcase
      end
    end
  end

endmodule

// [core/cbt_top.sv]
/*
  Bit timing and address map block of a CAN controller: APB slave
  for control registers, mailbox RAM and control RAM; pin control;
  bit timing through cbt_bit_timer.
  Assumes a single 25 MHz pclk and that the protocol kernel sits
  outside, taking bit events and giving the transmit bit.
*/
// Summary of operation
// - sync segment is exactly one quantum
// - propagation part programmable one to eight
// - phase one programmable, lengthened by resync
// - phase two two to eight, shortened
// - quantum divide is prescaler field plus one
// - first field prop+phase1, second phase2
// - bit quanta are both fields plus three
// - processing time is ceiling three over divide
// - compat mode decodes two 256-byte regions
// - compat mode offers sixteen mailboxes
// - full control region 128 bytes, ends 07Ch
// - full control RAM at mailbox base plus 1000h
// - full mode offers thirty-two mailboxes
// - mailbox RAM byte-writable general memory
// - compat mode shows the compat map
// - pins act as bus pins when enabled
// - reset starts in compat mode
`include "cbt_consts.svh"

module cbt_top (
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB request
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  // APB answer
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Transmit pin, three signals
  input wire logic bus_transmit_pin_in,
  output logic bus_transmit_pin_out,
  output logic bus_transmit_pin_oe,
  // Receive pin, three signals
  input wire logic bus_receive_pin_in,
  output logic bus_receive_pin_out,
  output logic bus_receive_pin_oe,
  // Protocol kernel side
  input wire logic kernel_tx_bit,
  output logic sample_strobe,
  output logic sampled_bit,
  output logic bit_start,
  output logic full_mode
);

  localparam int MBX_WORDS = `CBT_FULL_MBX_COUNT * 4;
  localparam int CRAM_WORDS =
    `CBT_FULL_MBX_COUNT * `CBT_CRAM_WORDS_PER_MBX;

  // ========================================================
  // Storage and registers
  logic [31:0] bit_timing_config; // Prescaler and segments
  logic [3:0] tx_pin_io_control; // Transmit pin function
  logic [3:0] rx_pin_io_control; // Receive pin function
  logic [31:0] compat_mask [3]; // Compat identifier masks
  logic [31:0] mbx_ram [MBX_WORDS]; // Mailbox words
  logic [31:0] cram [CRAM_WORDS]; // Mask, stamp, time-out

  // Pin synchronisers, first stage read only by second
  logic tx_meta, tx_sync;
  logic rx_meta, rx_sync;

  // Decode results
  cbt_pkg::cbt_region_t region; // Region hit
  logic [13:0] ofs; // Offset inside region
  logic ctrl_hit; // Mapped control register
  logic mbx_hit; // Mailbox within count
  logic cram_hit; // Control RAM word in range
  logic mapped; // Any legal target
  logic [6:0] mbx_idx; // Mailbox word index
  logic [6:0] cram_idx; // Control RAM word index
  logic [31:0] rd_mux; // Read value before register
  logic wr_en; // Write taken this edge
  logic [31:0] status_word; // Live timing status
  logic [1:0] info_processing_time; // Processing time in quanta
  logic [8:0] eff_divide; // Effective divide
  cbt_pkg::cbt_seg_t seg; // Current segment

  // ========================================================
  // Byte-lane merge for partial writes
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0] be
  );
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  // ========================================================
  // Region decode; reserved holes answer with an error
  always_comb begin
    region = cbt_pkg::CBT_REG_NONE;
    ofs = 14'h0000;
    if (paddr < `CBT_COMPAT_CTRL_SIZE) begin
      region = cbt_pkg::CBT_REG_CTRL;
      ofs = paddr - `CBT_CTRL_BASE;
    end else if (paddr >= `CBT_MBX_BASE + `CBT_CRAM_OFS) begin
      region = cbt_pkg::CBT_REG_CRAM;
      ofs = paddr - (`CBT_MBX_BASE + `CBT_CRAM_OFS);
    end else if (paddr >= `CBT_MBX_BASE) begin
      region = cbt_pkg::CBT_REG_MBX;
      ofs = paddr - `CBT_MBX_BASE;
    end
  end

  assign mbx_idx = ofs[8:2];
  assign cram_idx = ofs[8:2];

  always_comb begin
    ctrl_hit = 1'b0;
    mbx_hit = 1'b0;
    cram_hit = 1'b0;
    if (region == cbt_pkg::CBT_REG_CTRL) begin
      unique case (ofs & 14'h3FFC)
        `CBT_BIT_TIMING_CONFIG, `CBT_MODE_CONTROL,
        `CBT_TX_PIN_IO_CONTROL, `CBT_RX_PIN_IO_CONTROL,
        `CBT_TIMING_STATUS: begin
          ctrl_hit = 1'b1;
        end
        `CBT_COMPAT_MASK0, `CBT_COMPAT_MASK1,
        `CBT_COMPAT_MASK2: begin
          ctrl_hit = !full_mode;
        end
        default: begin
          ctrl_hit = 1'b0;
        end
      endcase
      if (full_mode && ofs > `CBT_FULL_CTRL_LAST) begin
        ctrl_hit = 1'b0;
      end
    end
    if (region == cbt_pkg::CBT_REG_MBX) begin
      mbx_hit = full_mode ?
        (ofs < `CBT_MBX_STRIDE * 14'(`CBT_FULL_MBX_COUNT)) :
        (ofs < `CBT_MBX_STRIDE * 14'(`CBT_COMPAT_MBX_COUNT));
    end
    if (region == cbt_pkg::CBT_REG_CRAM) begin
      // control RAM only in full mode
      cram_hit = full_mode && (ofs < 14'(CRAM_WORDS * 4));
    end
  end

  assign mapped = ctrl_hit || mbx_hit || cram_hit;

  // ========================================================
  // APB handshake: no wait states, error on unmapped
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign wr_en = psel && penable && pwrite && mapped;

  // ========================================================
  // Processing time and effective divide
  assign eff_divide = {1'b0, bit_timing_config[`CBT_PRESCALE_LSB +: 8]}
    + 9'h001;

  always_comb begin
    if (eff_divide == 9'h001) begin
      info_processing_time = 2'(`CBT_PROC_QUANTA);
    end else if (eff_divide == 9'h002) begin
      info_processing_time = 2'd2;
    end else begin
      info_processing_time = 2'd1;
    end
  end

  // Status: segment, sampled bit, processing time, mode
  assign status_word = {24'h000000, full_mode, rx_sync,
    info_processing_time, sampled_bit, 1'b0, seg};

  // ========================================================
  // Read mux, captured in setup so data comes from flops
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (ctrl_hit) begin
      unique case (ofs & 14'h3FFC)
        `CBT_BIT_TIMING_CONFIG: begin
          rd_mux = bit_timing_config;
        end
        `CBT_MODE_CONTROL: begin
          rd_mux = {31'h0, full_mode};
        end
        `CBT_TX_PIN_IO_CONTROL: begin
          rd_mux = {28'h0, tx_pin_io_control[3:1], tx_sync};
        end
        `CBT_RX_PIN_IO_CONTROL: begin
          rd_mux = {28'h0, rx_pin_io_control[3:1], rx_sync};
        end
        `CBT_TIMING_STATUS: begin
          rd_mux = status_word;
        end
        `CBT_COMPAT_MASK0: begin
          rd_mux = compat_mask[0];
        end
        `CBT_COMPAT_MASK1: begin
          rd_mux = compat_mask[1];
        end
        `CBT_COMPAT_MASK2: begin
          rd_mux = compat_mask[2];
        end
        default: begin
          rd_mux = 32'h0000_0000;
        end
      endcase
    end else if (mbx_hit) begin
      rd_mux = mbx_ram[mbx_idx];
    end else if (cram_hit) begin
      rd_mux = cram[cram_idx];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // ========================================================
  // Control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_timing_config <= `CBT_BTC_RESET;
      full_mode <= `CBT_MODE_RESET;
      tx_pin_io_control <= `CBT_IO_RESET;
      rx_pin_io_control <= `CBT_IO_RESET;
    end else if (wr_en && ctrl_hit) begin
      unique case (ofs & 14'h3FFC)
        // prop and phase1 share first field
        `CBT_BIT_TIMING_CONFIG: begin
          bit_timing_config <=
            merge(bit_timing_config, pwdata, pstrb);
        end
        `CBT_MODE_CONTROL: begin
          if (pstrb[0]) begin
            full_mode <= pwdata[`CBT_FULL_MODE_BIT];
          end
        end
        `CBT_TX_PIN_IO_CONTROL: begin
          if (pstrb[0]) begin
            tx_pin_io_control <= pwdata[3:0];
          end
        end
        `CBT_RX_PIN_IO_CONTROL: begin
          if (pstrb[0]) begin
            rx_pin_io_control <= pwdata[3:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ========================================================
  // Compat masks, one flop word each
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 3; i++) begin
        compat_mask[i] <= `CBT_MASK_RESET;
      end
    end else if (wr_en && ctrl_hit) begin
      for (int i = 0; i < 3; i++) begin
        if ((ofs & 14'h3FFC) == `CBT_COMPAT_MASK0 + 14'(4 * i)) begin
          compat_mask[i] <= merge(compat_mask[i], pwdata, pstrb);
        end
      end
    end
  end

  // ========================================================
  // Mailbox and control RAM; not reset, like a real RAM.
  // Software must disable a mailbox before using it as memory.
  always_ff @(posedge pclk) begin
    if (wr_en && mbx_hit) begin
      mbx_ram[mbx_idx] <= merge(mbx_ram[mbx_idx], pwdata, pstrb);
    end
  end

  always_ff @(posedge pclk) begin
    if (wr_en && cram_hit) begin
      cram[cram_idx] <= merge(cram[cram_idx], pwdata, pstrb);
    end
  end

  // ========================================================
  // Pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_meta <= 1'b1;
      tx_sync <= 1'b1;
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else begin
      tx_meta <= bus_transmit_pin_in;
      tx_sync <= tx_meta;
      rx_meta <= bus_receive_pin_in;
      rx_sync <= rx_meta;
    end
  end

  // ========================================================
  // Pin drivers; general purpose io when not bus pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_transmit_pin_out <= 1'b1;
      bus_transmit_pin_oe <= 1'b0;
      bus_receive_pin_out <= 1'b1;
      bus_receive_pin_oe <= 1'b0;
    end else begin
      if (tx_pin_io_control[`CBT_IO_FUNC_BIT]) begin
        bus_transmit_pin_out <= kernel_tx_bit;
        bus_transmit_pin_oe <= 1'b1;
      end else begin
        bus_transmit_pin_out <= tx_pin_io_control[`CBT_IO_OUT_BIT];
        bus_transmit_pin_oe <= tx_pin_io_control[`CBT_IO_DIR_BIT];
      end
      // Receive pin never drives in bus function
      if (rx_pin_io_control[`CBT_IO_FUNC_BIT]) begin
        bus_receive_pin_out <= 1'b1;
        bus_receive_pin_oe <= 1'b0;
      end else begin
        bus_receive_pin_out <= rx_pin_io_control[`CBT_IO_OUT_BIT];
        bus_receive_pin_oe <= rx_pin_io_control[`CBT_IO_DIR_BIT];
      end
    end
  end

  // ========================================================
  // Bit timer; idles until the receive pin is a bus pin
  // rate is pclk over divide times quanta
  cbt_bit_timer u_timer (
    .clk(pclk),
    .rst_n(presetn),
    .enable(rx_pin_io_control[`CBT_IO_FUNC_BIT]),
    .quantum_prescaler(bit_timing_config[`CBT_PRESCALE_LSB +: 8]),
    .first_timing_segment(bit_timing_config[`CBT_FIRST_SEG_LSB +: 4]),
    .second_timing_segment(bit_timing_config[`CBT_SECOND_SEG_LSB +: 3]),
    .resync_jump_width(bit_timing_config[`CBT_JUMP_LSB +: 2]),
    .triple_sample_select(bit_timing_config[`CBT_TRIPLE_BIT]),
    .rx_level(rx_sync),
    .sample_strobe(sample_strobe),
    .sampled_bit(sampled_bit),
    .bit_start(bit_start),
    .seg(seg)
  );

endmodule

// [testbench/cbt_asserts.sv]
/*
  Port checker for cbt_top.
  Assumes it is bound onto cbt_top, one pclk domain, reset presetn.
*/
module cbt_asserts (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // Bit events and mode
  input wire logic sample_strobe,
  input wire logic sampled_bit,
  input wire logic bit_start,
  input wire logic full_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Setup
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Access phase of a transfer
  wire acc = psel && penable;

  // ==========================================================
  // Address map
  chk_ready_high: assert property (pready)
    else $error("wait state inserted");
  chk_err_access: assert property (pslverr |-> acc)
    else $error("error outside access phase");
  chk_mbx_compat: assert property (acc && !full_mode
    && paddr >= 14'h2100 && paddr < 14'h2200 |-> pslverr)
    else $error("mailbox 16 up mapped in compat");
  chk_cram_compat: assert property (acc && !full_mode
    && paddr[13:12] == 2'h3 |-> pslverr)
    else $error("control RAM mapped in compat");
  chk_full_ctrl: assert property (acc && full_mode
    && paddr >= 14'h0080 && paddr < 14'h0100 |-> pslverr)
    else $error("full control region too large");
  // Mode only moves through a write to mode control
  chk_mode_cause: assert property ($changed(full_mode)
    |-> $past(acc && pwrite && paddr == 14'h0004))
    else $error("mode changed without write");

  // ==========================================================
  // Bit timing: a bit is at least four quanta of one cycle
  chk_start_gap: assert property (bit_start |=> !bit_start [*3])
    else $error("bit shorter than four quanta");
  chk_bit_hold: assert property ($changed(sampled_bit)
    |-> sample_strobe)
    else $error("sampled bit moved off strobe");

  cover property (bit_start);
  cover property (sample_strobe && !sampled_bit);
  cover property (acc && pslverr);
endmodule

bind cbt_top cbt_asserts u_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pready, .pslverr, .sample_strobe, .sampled_bit,
  .bit_start, .full_mode);

// [testbench/cbt_node.sv]
/*
  Another node on the bus, sending whole bits at its own phase.
  Assumes the bench sets the bit length in pclk cycles.
*/
module cbt_node (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control from bench
  input wire logic active,
  input wire logic bit_val,
  input wire logic [7:0] per,
  // Bus level, recessive high when idle
  output logic level
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // ==========================================================
  // same bit length as the design, free phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      level <= 1'b1;
    end else begin
      cnt <= (cnt >= per - 1) ? 0 : cnt + 1;
      // Bit changes only on a bit boundary
      if (cnt >= per - 1) begin
        level <= active ? bit_val : 1'b1;
      end
    end
  end
endmodule

// [testbench/can_bit_timing_and_memory_map_test.sv]
/*
  Self-checking bench for cbt_top: map, pins and bit timing.
  Assumes cbt_node as the far node and the bound checker.
*/
`include "cbt_consts.svh"

module can_bit_timing_and_memory_map_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [13:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, x;
  logic [3:0] pstrb = '0;
  logic ktx = 0, act = 0, bval = 1, er, pready, pslverr;
  logic [7:0] per = 8'h10;
  logic tx_in, tx_out, tx_oe, rx_lvl, rx_out, rx_oe, node_lvl;
  logic strobe, sbit, bstart, fmode;
  int errors = 0, tests_run = 0;
  localparam logic [13:0] MB = `CBT_MBX_BASE;
  // Wire level: pull-up on tx, far node level on rx, unless the pin's driver is enabled
  assign tx_in = tx_oe ? tx_out : 1'b1;
  assign rx_lvl = rx_oe ? rx_out : node_lvl;
  always #20 pclk = ~pclk;

  cbt_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .pready, .prdata, .pslverr,
    .bus_transmit_pin_in(tx_in), .bus_transmit_pin_out(tx_out),
    .bus_transmit_pin_oe(tx_oe), .bus_receive_pin_in(rx_lvl),
    .bus_receive_pin_out(rx_out), .bus_receive_pin_oe(rx_oe),
    .kernel_tx_bit(ktx), .sample_strobe(strobe), .sampled_bit(sbit),
    .bit_start(bstart), .full_mode(fmode));
  cbt_node u_node (.pclk, .presetn, .active(act), .bit_val(bval),
    .per, .level(node_lvl));

  // ==========================================================
  // Helpers
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until pready at a rising edge
  task automatic apb(input logic w, input logic [13:0] a,
      input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rc(input logic [13:0] a, input logic e,
      input logic [31:0] v);
    apb(1'b0, a, '0, '0);
    chk({er, rd}, {e, v});
  endtask
  // Cycles per bit from the programmed fields
  function automatic int bt(int b, int t1, int t2);
    return (b + 1) * (3 + t1 + t2);
  endfunction
  task automatic period(output int n);
    n = 0;
    @(posedge pclk iff bstart === 1'b1);
    do begin
      @(posedge pclk);
      n++;
    end while (bstart !== 1'b1);
  endtask
  task automatic results;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ==========================================================
  // Watchdog at 10000 cycles, far beyond the under two thousand cycles needed
  initial begin
    #400000;
    errors++;
    results();
  end

  initial begin
    int b, t1, t2, n;
    logic [31:0] cfg;
    void'($urandom(63204));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rc(`CBT_BIT_TIMING_CONFIG, 0, `CBT_BTC_RESET);
    chk(fmode, 0);
    $display("test reset done");
    // Known setting first, then random legal ones, divide two up
    for (int i = 0; i < 4; i++) begin
      b = i ? 1 + $urandom % 4 : 1;
      t2 = i ? 1 + $urandom % 3 : 2;
      t1 = i ? t2 + $urandom % 4 : 3;
      cfg = {8'h00, b[7:0], 6'h00, i ? 2'h0 : 2'h2,
        1'(i && b > 3), t1[3:0], t2[2:0]};
      apb(1'b1, `CBT_RX_PIN_IO_CONTROL, 32'h0, 4'hF);
      apb(1'b1, `CBT_BIT_TIMING_CONFIG, cfg, 4'hF);
      rc(`CBT_BIT_TIMING_CONFIG, 0, cfg);
      apb(1'b0, `CBT_TIMING_STATUS, '0, '0);
      chk({er, rd[5:4]}, {1'b0, 2'((3 + b) / (b + 1))});
      apb(1'b1, `CBT_RX_PIN_IO_CONTROL, 32'h8, 4'hF);
      period(n);
      period(n);
      chk(n, bt(b, t1, t2));
    end
    $display("test bit length done");
    per <= 8'(bt(b, t1, t2));
    act <= 1'b1;
    for (int v = 0; v < 2; v++) begin
      bval <= 1'(v);
      repeat (3) @(posedge pclk iff strobe === 1'b1);
      chk(sbit, v);
    end
    act <= 1'b0;
    apb(1'b1, `CBT_TX_PIN_IO_CONTROL, 32'h8, 4'hF);
    repeat (6) begin
      ktx <= 1'($urandom);
      repeat (2) @(posedge pclk);
      chk({rx_oe, tx_oe, tx_out}, {2'b01, ktx});
    end
    // Receive pin as driven general io, read back through the pin
    apb(1'b1, `CBT_RX_PIN_IO_CONTROL, 32'h4, 4'h1);
    repeat (4) @(posedge pclk);
    chk({rx_oe, rx_out}, 2'b10);
    rc(`CBT_RX_PIN_IO_CONTROL, 0, 32'h4);
    $display("test pins done");
    x = $urandom;
    apb(1'b1, MB + 14'h00F0, x, 4'hF);
    apb(1'b1, MB + 14'h00F0, 32'h0000_00C3, 4'h1);
    rc(MB + 14'h00F0, 0, {x[31:8], 8'hC3});
    rc(MB + 14'h0100, 1, 0);
    rc(MB + `CBT_CRAM_OFS, 1, 0);
    rc(`CBT_COMPAT_MASK0, 0, `CBT_MASK_RESET);
    apb(1'b1, `CBT_MODE_CONTROL, 32'h1, 4'h1);
    rc(`CBT_MODE_CONTROL, 0, 32'h1);
    chk(fmode, 1);
    apb(1'b1, MB + 14'h01FC, x, 4'hF);
    apb(1'b1, MB + `CBT_CRAM_OFS + 14'h017C, ~x, 4'hF);
    rc(MB + 14'h01FC, 0, x);
    rc(MB + `CBT_CRAM_OFS + 14'h017C, 0, ~x);
    rc(14'h0080, 1, 0);
    $display("test map done");
    results();
  end
endmodule
